// ---- rps_pkg.sv ----
package rps_pkg;

    // Field and pin geometry.
    localparam int SEL_WIDTH = 5;
    localparam int MAX_PINS = 26;
    localparam int OSC_BYTE_WIDTH = 8;

    // Reset values of the select fields and of the lock.
    localparam logic [4:0] IN_SEL_RESET = 5'h1F;
    localparam logic [4:0] OUT_SEL_RESET = 5'h00;
    localparam logic LOCK_RESET = 1'b0;

    // Input select code that ties a peripheral input low.
    localparam logic [4:0] IN_SEL_GROUND = 5'h1F;

    // Unlock keys and lock bit position in the oscillator control byte.
    localparam logic [7:0] KEY_FIRST = 8'h46;
    localparam logic [7:0] KEY_SECOND = 8'h57;
    localparam int OSC_LOCK_BIT = 6;

    // Output select codes.
    localparam logic [4:0] OUT_NULL = 5'h00;
    localparam logic [4:0] OUT_CMP1 = 5'h01;
    localparam logic [4:0] OUT_CMP2 = 5'h02;
    localparam logic [4:0] OUT_UART1_TX = 5'h03;
    localparam logic [4:0] OUT_UART1_RTS = 5'h04;
    localparam logic [4:0] OUT_UART2_TX = 5'h05;
    localparam logic [4:0] OUT_UART2_RTS = 5'h06;
    localparam logic [4:0] OUT_SPI1_DATA = 5'h07;
    localparam logic [4:0] OUT_SPI1_CLOCK = 5'h08;
    localparam logic [4:0] OUT_SPI1_SELECT = 5'h09;
    localparam logic [4:0] OUT_SPI2_DATA = 5'h0A;
    localparam logic [4:0] OUT_SPI2_CLOCK = 5'h0B;
    localparam logic [4:0] OUT_SPI2_SELECT = 5'h0C;
    localparam logic [4:0] OUT_CAN_TX = 5'h10;
    localparam logic [4:0] OUT_COMPARE1 = 5'h12;
    localparam logic [4:0] OUT_COMPARE2 = 5'h13;
    localparam logic [4:0] OUT_COMPARE3 = 5'h14;
    localparam logic [4:0] OUT_COMPARE4 = 5'h15;
    localparam logic [4:0] OUT_ENC1_DIR = 5'h1A;
    localparam logic [4:0] OUT_ENC2_DIR = 5'h1B;

    // Index of each peripheral input select field.
    typedef enum logic [4:0] {
        IN_EXT_INT1, IN_EXT_INT2, IN_T2_CLK, IN_T3_CLK, IN_T4_CLK,
        IN_T5_CLK, IN_CAPTURE1, IN_CAPTURE2, IN_CAPTURE7, IN_CAPTURE8,
        IN_COMPARE_FAULT_A, IN_PWM_FAULT1, IN_PWM_FAULT2,
        IN_ENC1_PHASE_A, IN_ENC1_PHASE_B, IN_ENC1_INDEX,
        IN_ENC2_PHASE_A, IN_ENC2_PHASE_B, IN_ENC2_INDEX,
        IN_UART1_RX, IN_UART1_CTS, IN_UART2_RX, IN_UART2_CTS,
        IN_SPI1_DATA, IN_SPI1_CLOCK, IN_SPI1_SELECT,
        IN_SPI2_DATA, IN_SPI2_CLOCK, IN_SPI2_SELECT, IN_CAN_RX,
        IN_COUNT
    } rps_input_id_t;

    // Unlock sequence states, Gray coded along the key path.
    typedef enum logic [1:0] {
        UNL_IDLE = 2'h0,
        UNL_GOT_FIRST = 2'h1,
        UNL_GOT_SECOND = 2'h3
    } rps_unlock_t;

    // One write to a select field.
    typedef struct packed {
        logic en;
        logic isOutput;
        logic [4:0] index;
        logic [4:0] data;
    } rps_map_wr_t;

    // One write to the low byte of the oscillator control register.
    typedef struct packed {
        logic en;
        logic [7:0] data;
    } rps_osc_wr_t;

    // Peripheral outputs that can be routed to a pin.
    typedef struct packed {
        logic comparatorOneOutput;
        logic comparatorTwoOutput;
        logic uartOneTx;
        logic uartOneRts;
        logic uartTwoTx;
        logic uartTwoRts;
        logic spiOneDataOut;
        logic spiOneClock;
        logic spiOneSelect;
        logic spiTwoDataOut;
        logic spiTwoClock;
        logic spiTwoSelect;
        logic canTransmitOutput;
        logic compareOne;
        logic compareTwo;
        logic compareThree;
        logic compareFour;
        logic encoderOneDirection;
        logic encoderTwoDirection;
    } rps_periph_out_t;

endpackage

// ---- rps_select_bank.sv ----
`timescale 1ns/1ps
module rps_select_bank
    import rps_pkg::*;
#(
    parameter int COUNT = 30,
    parameter logic [4:0] RESET_VAL = 5'h00
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Write request.
    input wire logic wrEn,
    input wire logic wrBlock,
    input wire logic [4:0] wrIndex,
    input wire logic [4:0] wrData,
    // Stored fields.
    output logic [COUNT-1:0][4:0] fields
);

    // A five-bit index reaches at most thirty-two fields.
    if (COUNT < 1 || COUNT > 32) begin : gBadCount
        $error("rps_select_bank: COUNT out of range");
    end

    // A blocked write is accepted silently and leaves the field as it was.
    always_ff @(posedge clock) begin
        if (rst) begin
            fields <= {COUNT{RESET_VAL}};
        end else if (wrEn && !wrBlock && (int'(wrIndex) < COUNT)) begin
            fields[wrIndex] <= wrData;
        end
    end

endmodule

// ---- rps_pin_select.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Up to twenty-six remappable pins, count device dependent.
// - Input and output maps are separate registers.
// - Five-bit input field selects pin n.
// - Valid select range follows present pin count.
// - Thirty peripheral inputs each have a field.
// - Five-bit output field per pin selects source.
// - Code zero leaves pin to port logic.
// - Codes one, two route comparator outputs.
// - Codes three to six route UART outputs.
// - Codes seven to twelve route SPI outputs.
// - Code sixteen routes CAN transmit.
// - Codes eighteen to twenty-one route compares.
// - Codes twenty-six, twenty-seven route encoder direction.
// - Input code thirty-one ties input low.
// - Locked writes complete but change nothing.
// - Lock changes only after two key writes.
// - Single-session option keeps lock set until reset.
module rps_pin_select
    import rps_pkg::*;
#(
    parameter int NUM_PINS = 26
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Configuration option, static while running.
    input wire logic singleSessionOption,
    // Software writes.
    input wire rps_map_wr_t mapWr,
    input wire rps_osc_wr_t oscWr,
    // Remappable pin levels and peripheral outputs.
    input wire logic [NUM_PINS-1:0] pinIn,
    input wire rps_periph_out_t periphOut,
    // Routed peripheral inputs.
    output logic [IN_COUNT-1:0] periphIn,
    // Pin drive: own high means a peripheral drives the pin.
    output logic [NUM_PINS-1:0] pinPeriphOwn,
    output logic [NUM_PINS-1:0] pinPeriphData,
    // Readback.
    output logic mapLock,
    output logic [IN_COUNT-1:0][4:0] inSelect,
    output logic [NUM_PINS-1:0][4:0] outSelect
);

    // The fields can only name the pins that this family brings out.
    if (NUM_PINS < 1 || NUM_PINS > MAX_PINS) begin : gBadPins
        $error("rps_pin_select: NUM_PINS out of range");
    end

    rps_unlock_t unlockState;
    logic oneWay;
    logic next_lock;

    // The option is a fuse-like level, captured on every edge while reset is held.
    always_ff @(posedge clock) begin
        if (rst) begin
            oneWay <= singleSessionOption;
        end
    end

    // Two separate banks, so inputs and outputs never constrain each other.
    rps_select_bank #(
        .COUNT(IN_COUNT),
        .RESET_VAL(IN_SEL_RESET)
    ) inBank (
        .clock(clock),
        .rst(rst),
        .wrEn(mapWr.en && !mapWr.isOutput),
        .wrBlock(mapLock),
        .wrIndex(mapWr.index),
        .wrData(mapWr.data),
        .fields(inSelect)
    );

    rps_select_bank #(
        .COUNT(NUM_PINS),
        .RESET_VAL(OUT_SEL_RESET)
    ) outBank (
        .clock(clock),
        .rst(rst),
        .wrEn(mapWr.en && mapWr.isOutput),
        .wrBlock(mapLock),
        .wrIndex(mapWr.index),
        .wrData(mapWr.data),
        .fields(outSelect)
    );

    // Key tracker; only oscillator byte writes move it, other cycles hold.
    always_ff @(posedge clock) begin
        if (rst) begin
            unlockState <= UNL_IDLE;
        end else if (oscWr.en) begin
            unique case (unlockState)
                UNL_IDLE: begin
                    unlockState <= (oscWr.data == KEY_FIRST) ?
                        UNL_GOT_FIRST : UNL_IDLE;
                end
                UNL_GOT_FIRST: begin
                    if (oscWr.data == KEY_SECOND) begin
                        unlockState <= UNL_GOT_SECOND;
                    end else if (oscWr.data == KEY_FIRST) begin
                        unlockState <= UNL_GOT_FIRST;
                    end else begin
                        unlockState <= UNL_IDLE;
                    end
                end
                UNL_GOT_SECOND: begin
                    unlockState <= UNL_IDLE;
                end
                // The unused code can only come from an upset; drop to idle.
                default: begin
                    unlockState <= UNL_IDLE;
                end
            endcase
        end
    end

    // Once set under the single-session option the lock cannot clear.
    assign next_lock = oscWr.data[OSC_LOCK_BIT] | (oneWay & mapLock);

    // The write after both keys is the single operation that moves the lock.
    always_ff @(posedge clock) begin
        if (rst) begin
            mapLock <= LOCK_RESET;
        end else if (oscWr.en && unlockState == UNL_GOT_SECOND) begin
            mapLock <= next_lock;
        end
    end

    // Source for each output code; unassigned codes fall to null.
    function automatic logic [1:0] routeOut(input logic [4:0] code,
                                            input rps_periph_out_t po);
        logic [1:0] r;
        r = 2'h0;
        unique case (code)
            OUT_CMP1: r = {1'b1, po.comparatorOneOutput};
            OUT_CMP2: r = {1'b1, po.comparatorTwoOutput};
            OUT_UART1_TX: r = {1'b1, po.uartOneTx};
            OUT_UART1_RTS: r = {1'b1, po.uartOneRts};
            OUT_UART2_TX: r = {1'b1, po.uartTwoTx};
            OUT_UART2_RTS: r = {1'b1, po.uartTwoRts};
            OUT_SPI1_DATA: r = {1'b1, po.spiOneDataOut};
            OUT_SPI1_CLOCK: r = {1'b1, po.spiOneClock};
            OUT_SPI1_SELECT: r = {1'b1, po.spiOneSelect};
            OUT_SPI2_DATA: r = {1'b1, po.spiTwoDataOut};
            OUT_SPI2_CLOCK: r = {1'b1, po.spiTwoClock};
            OUT_SPI2_SELECT: r = {1'b1, po.spiTwoSelect};
            OUT_CAN_TX: r = {1'b1, po.canTransmitOutput};
            OUT_COMPARE1: r = {1'b1, po.compareOne};
            OUT_COMPARE2: r = {1'b1, po.compareTwo};
            OUT_COMPARE3: r = {1'b1, po.compareThree};
            OUT_COMPARE4: r = {1'b1, po.compareFour};
            OUT_ENC1_DIR: r = {1'b1, po.encoderOneDirection};
            OUT_ENC2_DIR: r = {1'b1, po.encoderTwoDirection};
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    // Unlock steps, used by the lock checks.
    sequence keyOne;
        oscWr.en && unlockState == UNL_IDLE && oscWr.data == KEY_FIRST;
    endsequence
    sequence keyTwo;
        oscWr.en && oscWr.data == KEY_SECOND;
    endsequence
    sequence lockWrite;
        oscWr.en;
    endsequence

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // One registered stage per peripheral input.
    genvar gi;
    generate
        for (gi = 0; gi < IN_COUNT; gi++) begin : gIn
            logic sel;
            // Absent pins and the ground code both read as low.
            assign sel = (int'(inSelect[gi]) < NUM_PINS) ?
                pinIn[inSelect[gi]] : 1'b0;
            always_ff @(posedge clock) begin
                if (rst) begin
                    periphIn[gi] <= 1'b0;
                end else begin
                    periphIn[gi] <= sel;
                end
            end
            a_input_ground: assert property (
                inSelect[gi] == IN_SEL_GROUND |=> !periphIn[gi])
                else $error("grounded input not low");
            a_absent_pin_low: assert property (
                int'(inSelect[gi]) >= NUM_PINS |=> !periphIn[gi])
                else $error("absent pin input not low");
        end
    endgenerate

    // Pin 0 routing checked against the raw pin level.
    a_input_route: assert property (
        inSelect[IN_EXT_INT1] == 5'h00 |=> periphIn[IN_EXT_INT1] ==
        $past(pinIn[0]))
        else $error("input not routed from selected pin");

    // One registered stage per remappable pin.
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : gPin
            logic [1:0] route;
            assign route = routeOut(outSelect[gp], periphOut);
            always_ff @(posedge clock) begin
                if (rst) begin
                    pinPeriphOwn[gp] <= 1'b0;
                    pinPeriphData[gp] <= 1'b0;
                end else begin
                    pinPeriphOwn[gp] <= route[1];
                    pinPeriphData[gp] <= route[1] & route[0];
                end
            end
            a_null_released: assert property (
                outSelect[gp] == OUT_NULL |=> !pinPeriphOwn[gp])
                else $error("null code still drives pin");
            a_unassigned_null: assert property (
                (outSelect[gp] == 5'h0D || outSelect[gp] == 5'h11 ||
                 outSelect[gp] == 5'h1F) |=> !pinPeriphOwn[gp])
                else $error("unassigned code drives pin");
            a_can_routed: assert property (
                outSelect[gp] == OUT_CAN_TX |=> pinPeriphOwn[gp] &&
                pinPeriphData[gp] == $past(periphOut.canTransmitOutput))
                else $error("transmit not routed to pin");
        end
    endgenerate

    a_locked_write: assert property (
        mapLock && mapWr.en |=> $stable(inSelect) && $stable(outSelect))
        else $error("select changed while locked");
    a_unlocked_write: assert property (
        !mapLock && mapWr.en && !mapWr.isOutput &&
        int'(mapWr.index) < IN_COUNT |=>
        inSelect[$past(mapWr.index)] == $past(mapWr.data))
        else $error("unlocked input write not stored");
    a_lock_keyed: assert property (
        !$stable(mapLock) |-> $past(unlockState) == UNL_GOT_SECOND &&
        $past(oscWr.en))
        else $error("lock moved without key sequence");
    a_unlock_clear: assert property (
        keyOne ##1 keyTwo ##1 (lockWrite and
        !oscWr.data[OSC_LOCK_BIT] && !oneWay) |=> !mapLock)
        else $error("key sequence failed to clear lock");
    a_one_way_hold: assert property (
        oneWay && mapLock |=> mapLock)
        else $error("single-session lock cleared");

endmodule

// ---- rps_far_side.sv ----
`timescale 1ns/1ps
module rps_far_side
    import rps_pkg::*;
(
    // Levels chosen by the scenario, and the block's pin drive.
    input wire logic [MAX_PINS-1:0] pinDir,
    input wire logic [MAX_PINS-1:0] pinLevel,
    input wire logic [MAX_PINS-1:0] pinPeriphData,
    input wire rps_periph_out_t periphLevel,
    // Toward the block.
    output logic [MAX_PINS-1:0] pinIn,
    output rps_periph_out_t periphOut
);
    // An output pin reads back its own drive, so inputs need direction 1.
    assign pinIn = (pinDir & pinLevel) | (~pinDir & pinPeriphData);
    // Peripherals present their outputs without delay.
    assign periphOut = periphLevel;
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import rps_pkg::*;
;
    logic clock, rst, singleSessionOption;
    rps_map_wr_t mapWr;
    rps_osc_wr_t oscWr;
    logic [MAX_PINS-1:0] pinDir, pinLevel, pinIn, pinPeriphOwn, pinPeriphData;
    rps_periph_out_t periphLevel, periphOut;
    logic [IN_COUNT-1:0] periphIn;
    logic mapLock;
    logic [IN_COUNT-1:0][4:0] inSelect;
    logic [MAX_PINS-1:0][4:0] outSelect;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    int src;
    // Source field for each output code, -1 where the code is unassigned.
    localparam int SRC [32] = '{-1, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11,
        -1, -1, -1, 12, -1, 13, 14, 15, 16, -1, -1, -1, -1, 17, 18,
        -1, -1, -1, -1};

    rps_pin_select #(.NUM_PINS(MAX_PINS)) u_rps_pin_select (
        .clock(clock), .rst(rst), .singleSessionOption(singleSessionOption),
        .mapWr(mapWr), .oscWr(oscWr), .pinIn(pinIn), .periphOut(periphOut),
        .periphIn(periphIn), .pinPeriphOwn(pinPeriphOwn),
        .pinPeriphData(pinPeriphData), .mapLock(mapLock),
        .inSelect(inSelect), .outSelect(outSelect));

    rps_far_side u_rps_far_side (
        .pinDir(pinDir), .pinLevel(pinLevel), .pinPeriphData(pinPeriphData),
        .periphLevel(periphLevel), .pinIn(pinIn), .periphOut(periphOut));

    // Free-running clock at 50 ns.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // A hang is cut short well beyond the few hundred cycles needed.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick();
        @(negedge clock);
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Write held for one edge, then one more edge for the routing stage.
    task automatic mapWrite(input logic isOut, input logic [4:0] idx,
                            input logic [4:0] d);
        mapWr = '{1'b1, isOut, idx, d};
        tick();
        mapWr.en = 1'b0;
        tick();
    endtask

    task automatic oscWrite(input logic [7:0] d);
        oscWr = '{1'b1, d};
        tick();
        oscWr.en = 1'b0;
        tick();
    endtask

    // Both keys and the lock write on back-to-back edges, strobe held up.
    task automatic unlockWrite(input logic [7:0] d);
        oscWr = '{1'b1, KEY_FIRST};
        tick();
        oscWr.data = KEY_SECOND;
        tick();
        oscWr.data = d;
        tick();
        oscWr.en = 1'b0;
        tick();
    endtask

    // Reset for eight cycles, then the reset values are compared.
    task automatic resetDut();
        rst = 1'b1;
        repeat (8) tick();
        rst = 1'b0;
        check("mapLock", 0, mapLock);
        check("inSelect", IN_SEL_RESET, inSelect[IN_CAN_RX]);
        check("outSelect", OUT_SEL_RESET, outSelect[0]);
        check("periphIn", 0, periphIn);
        check("pinPeriphOwn", 0, pinPeriphOwn);
    endtask

    initial begin
        rst = 1'b1;
        singleSessionOption = 1'b0;
        mapWr = '0;
        oscWr = '0;
        pinDir = '1;
        pinLevel = '0;
        periphLevel = '0;
        tick();
        resetDut();
        // Every output code on the highest pin, source proven by a one-hot.
        for (int code = 0; code < 32; code++) begin
            src = SRC[code];
            mapWrite(1'b1, 5'd25, 5'(code));
            periphLevel = (src < 0) ? '1 : rps_periph_out_t'(19'h1 << (18 - src));
            tick();
            check("outSelect", code, outSelect[25]);
            check("pinPeriphOwn", src >= 0, pinPeriphOwn[25]);
            check("pinPeriphData", src >= 0, pinPeriphData[25]);
            periphLevel = ~periphLevel;
            tick();
            check("pinPeriphData", 0, pinPeriphData[25]);
        end
        // Every peripheral input mapped to the pin of its own index.
        for (int id = 0; id < IN_COUNT; id++) begin
            mapWrite(1'b0, 5'(id), 5'(id));
            pinLevel = (id < MAX_PINS) ? 26'h1 << id : '1;
            tick();
            check("inSelect", id, inSelect[id]);
            check("periphIn", id < MAX_PINS, periphIn[id]);
            pinLevel = ~pinLevel;
            tick();
            check("periphIn", 0, periphIn[id]);
        end
        check("outSelect", 5'h1F, outSelect[25]);
        mapWrite(1'b0, IN_UART1_RX, IN_SEL_GROUND);
        pinLevel = '1;
        tick();
        check("periphIn", 0, periphIn[IN_UART1_RX]);
        // A pin set to output reads back its own peripheral drive.
        mapWrite(1'b1, 5'h19, OUT_CMP1);
        mapWrite(1'b0, IN_EXT_INT2, 5'h19);
        pinDir[25] = 1'b0;
        pinLevel = '0;
        periphLevel = '1;
        repeat (2) tick();
        check("periphIn", 1, periphIn[IN_EXT_INT2]);
        pinDir = '1;
        // Lock, then writes to both banks must change nothing.
        oscWrite(KEY_FIRST);
        oscWrite(KEY_SECOND);
        oscWrite(8'h40);
        check("mapLock", 1, mapLock);
        mapWrite(1'b1, 5'd0, OUT_CMP1);
        mapWrite(1'b0, 5'd0, 5'h05);
        check("outSelect", 0, outSelect[0]);
        check("inSelect", 0, inSelect[0]);
        // Broken key order leaves the lock alone.
        oscWrite(KEY_FIRST);
        oscWrite(8'h00);
        oscWrite(KEY_SECOND);
        oscWrite(8'h00);
        check("mapLock", 1, mapLock);
        // A repeated first key still counts as the first key.
        oscWrite(KEY_FIRST);
        oscWrite(KEY_FIRST);
        oscWrite(KEY_SECOND);
        oscWrite(8'h00);
        check("mapLock", 0, mapLock);
        mapWrite(1'b1, 5'd0, OUT_CMP1);
        check("outSelect", OUT_CMP1, outSelect[0]);
        // Single-session option: once set the lock holds until reset.
        singleSessionOption = 1'b1;
        resetDut();
        oscWrite(KEY_FIRST);
        oscWrite(KEY_SECOND);
        oscWrite(8'h40);
        oscWrite(KEY_FIRST);
        oscWrite(KEY_SECOND);
        oscWrite(8'h00);
        check("mapLock", 1, mapLock);
        singleSessionOption = 1'b0;
        resetDut();
        unlockWrite(8'h40);
        check("mapLock", 1, mapLock);
        unlockWrite(8'h00);
        check("mapLock", 0, mapLock);
        finish_test();
    end
endmodule
